//--- dv/pts_timebase_monitor.sv
// Port checker for the PWM time base, bound to every instance
`timescale 1ns/1ps
`default_nettype none
module pts_timebase_monitor
	import pts_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write response seen on the bus
	input wire logic s_axi_bvalid,
	// Time base outputs
	input wire logic [11:0] timebase_count,
	input wire logic count_direction_flag,
	input wire logic period_match,
	input wire logic count_zero,
	input wire logic pwm_hold_inactive,
	input wire logic timebase_event,
	input wire logic timebase_event_flag
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Counting up steps by one or wraps to zero
	a_count_up: assert property ($changed(timebase_count) && !count_direction_flag
		&& !$past(count_direction_flag) && !$rose(s_axi_bvalid)
		|-> timebase_count - $past(timebase_count) == 12'h001 || timebase_count == 12'h000)
		else $error("count up step wrong");
	// Counting down steps by one
	a_count_down: assert property ($changed(timebase_count) && count_direction_flag
		&& $past(count_direction_flag) && !$rose(s_axi_bvalid)
		|-> $past(timebase_count) - timebase_count == 12'h001)
		else $error("count down step wrong");
	// Ticks come no faster than the instruction rate
	a_tick_spacing: assert property ($changed(timebase_count) && !$rose(s_axi_bvalid)
		|=> (!$changed(timebase_count) || $rose(s_axi_bvalid)) [*3])
		else $error("ticks too close");
	// Turning upward at zero
	a_zero_turn: assert property (count_zero
		|-> !count_direction_flag && timebase_count == 12'h001)
		else $error("zero turn wrong");
	// Hold released only once counting down
	a_hold_release: assert property ($fell(pwm_hold_inactive) |-> count_direction_flag)
		else $error("hold released early");
	// Event pulse sets the flag
	a_event_flag: assert property (timebase_event |-> timebase_event_flag)
		else $error("flag not set");
	// Event is one cycle long
	a_event_pulse: assert property (timebase_event |=> !timebase_event)
		else $error("event too long");
	// Match is one cycle long
	a_match_pulse: assert property (period_match |=> !period_match)
		else $error("match too long");
	// Flag drops only by a register write
	a_flag_clear: assert property ($fell(timebase_event_flag) |-> $rose(s_axi_bvalid))
		else $error("flag lost");
	// Main scenarios reached
	c_event: cover property (timebase_event);
	c_zero: cover property (count_zero);
	c_hold: cover property ($fell(pwm_hold_inactive));
	c_clear: cover property ($fell(timebase_event_flag));
endmodule // pts_timebase_monitor
bind pts_timebase pts_timebase_monitor u_mon (.*);
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the PWM time base
`timescale 1ns/1ps
`default_nettype none
module tb
	import pts_pkg::*;
;
	// Bus drivers
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	// Design outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [11:0] timebase_count;
	logic count_direction_flag, period_match, count_zero, pwm_hold_inactive;
	logic timebase_event, timebase_event_flag;
	// Bench state
	int miscompares = 0, check_count = 0, n, k, i;
	logic [31:0] rv;
	logic [1:0] rs;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [1:0] s;} pts_row_type;
	pts_row_type rows [7] = '{'{PTS_CTRL0_OFF, 32'hA5, 32'hA5, PTS_RESP_OKAY},
		'{PTS_CTRL1_OFF, 32'h40, 32'h00, PTS_RESP_OKAY},
		'{PTS_PERL_OFF, 32'h3C, 32'h3C, PTS_RESP_OKAY},
		'{PTS_PERH_OFF, 32'hF7, 32'h07, PTS_RESP_OKAY},
		'{PTS_ACTPER_OFF, 32'h0, 32'h73C, PTS_RESP_OKAY},
		'{PTS_COUNT_OFF, 32'h123, 32'h123, PTS_RESP_OKAY},
		'{8'h1C, 32'hFF, 32'h0, PTS_RESP_SLVERR}};

	pts_timebase u_dut (.*);

	// 125 MHz clock
	always #4 aclk = ~aclk;

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask

	// Bus read
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask

	// Cycles between two successive events
	task automatic gap();
		n = 0;
		while (timebase_event !== 1'h1 && n < 3000)
		begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (timebase_event !== 1'h1 && n < 3000);
	endtask

	// Verdict
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Longest path is about 4500 cycles
	initial
	begin
		#320000;
		miscompares++;
		finish_test();
	end

	// Test sequence
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (i = 0; i < 28; i += 4)
		begin
			rd(8'(i));
			chk(rv, 0);
		end
		foreach (rows[j])
		begin
			wr(rows[j].a, rows[j].d);
			chk(rs, rows[j].s);
			rd(rows[j].a);
			chk(rv, rows[j].r);
			chk(rs, rows[j].s);
		end
		$display("Test registers done");
		wr(PTS_PERL_OFF, 32'h03);
		wr(PTS_PERH_OFF, 32'h00);
		wr(PTS_COUNT_OFF, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(PTS_CTRL0_OFF, 32'(i << 2));
			wr(PTS_CTRL1_OFF, 32'h80);
			gap();
			chk(n, 16 << (2 * i));
		end
		wr(PTS_CTRL0_OFF, 32'h20);
		gap();
		chk(n, 48);
		wr(PTS_CTRL0_OFF, 32'h30);
		gap();
		// Step two matches past the event so the postscaler is mid-count
		repeat (2)
		begin
			@(posedge aclk);
			while (period_match !== 1'h1) @(posedge aclk);
		end
		wr(PTS_CTRL0_OFF, 32'h30);
		k = 0;
		n = 0;
		while (timebase_event !== 1'h1 && n < 2000)
		begin
			@(posedge aclk);
			n++;
			if (period_match === 1'h1) k++;
		end
		chk(k, 4);
		chk(timebase_event_flag, 1);
		wr(PTS_EVT_OFF, 32'h1);
		rd(PTS_EVT_OFF);
		chk(rv, 0);
		$display("Test scalers done");
		wr(PTS_CTRL0_OFF, 32'h0C);
		wr(PTS_COUNT_OFF, 32'h2);
		wr(PTS_CTRL1_OFF, 32'h0);
		rd(PTS_COUNT_OFF);
		chk(rv, 2);
		wr(PTS_CTRL0_OFF, 32'h0C);
		rd(PTS_COUNT_OFF);
		chk(rv, 2);
		wr(PTS_CTRL1_OFF, 32'h80);
		repeat (130) @(posedge aclk);
		wr(PTS_COUNT_OFF, 32'h0);
		n = 0;
		while (timebase_count === 12'h000 && n < 600)
		begin
			@(posedge aclk);
			n++;
		end
		chk(n > 240 && n < 262, 1);
		$display("Test stop and clear done");
		wr(PTS_CTRL1_OFF, 32'h0);
		wr(PTS_CTRL0_OFF, 32'h0);
		wr(PTS_PERL_OFF, 32'h20);
		wr(PTS_COUNT_OFF, 32'h0);
		wr(PTS_CTRL1_OFF, 32'h80);
		gap();
		chk(n, 132);
		wr(PTS_PERL_OFF, 32'h05);
		rd(PTS_ACTPER_OFF);
		chk(rv, 32'h20);
		gap();
		chk(n, 24);
		$display("Test period reload done");
		wr(PTS_CTRL1_OFF, 32'h0);
		wr(PTS_CTRL0_OFF, 32'hF1);
		wr(PTS_COUNT_OFF, 32'h0);
		wr(PTS_CTRL1_OFF, 32'h80);
		k = 0;
		// Window of several periods
		repeat (200)
		begin
			@(posedge aclk);
			if (timebase_event === 1'h1) k++;
		end
		chk(k, 1);
		rd(PTS_CTRL1_OFF);
		chk(rv, 0);
		chk(timebase_count, 0);
		$display("Test single shot done");
		wr(PTS_CTRL0_OFF, 32'h02);
		chk(pwm_hold_inactive, 1);
		wr(PTS_CTRL1_OFF, 32'h80);
		gap();
		chk(n, 40);
		n = 0;
		while (count_direction_flag !== 1'h1 && n < 500)
		begin
			@(posedge aclk);
			n++;
		end
		rd(PTS_CTRL1_OFF);
		chk(rv, 32'hC0);
		chk(pwm_hold_inactive, 0);
		wr(PTS_CTRL1_OFF, 32'h0);
		wr(PTS_CTRL0_OFF, 32'h03);
		wr(PTS_COUNT_OFF, 32'h0);
		wr(PTS_CTRL1_OFF, 32'h80);
		gap();
		chk(n, 20);
		// Buffered period waits for the zero point
		while (period_match !== 1'h1) @(posedge aclk);
		wr(PTS_PERL_OFF, 32'h08);
		rd(PTS_ACTPER_OFF);
		chk(rv, 32'h05);
		while (count_zero !== 1'h1) @(posedge aclk);
		gap();
		chk(n, 32);
		$display("Test up down done");
		// Reset in mid-run clears state and registers
		aresetn <= 1'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		chk(timebase_count, 0);
		chk(count_direction_flag, 0);
		chk(timebase_event_flag, 0);
		rd(PTS_CTRL1_OFF);
		chk(rv, 0);
		rd(PTS_CTRL0_OFF);
		chk(rv, 0);
		$display("Test reset done");
		finish_test();
	end
endmodule // tb
`default_nettype wire

//--- hw/pts_pkg.sv
// Constants and types shared by the PWM time base block
package pts_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] PTS_CTRL0_OFF = 8'h00;
	localparam logic [7:0] PTS_CTRL1_OFF = 8'h04;
	localparam logic [7:0] PTS_PERL_OFF = 8'h08;
	localparam logic [7:0] PTS_PERH_OFF = 8'h0C;
	localparam logic [7:0] PTS_COUNT_OFF = 8'h10;
	localparam logic [7:0] PTS_ACTPER_OFF = 8'h14;
	localparam logic [7:0] PTS_EVT_OFF = 8'h18;

	// Field positions
	localparam int PTS_POST_LSB = 4;
	localparam int PTS_PRE_LSB = 2;
	localparam int PTS_MODE_LSB = 0;
	localparam int PTS_EN_BIT = 7;
	localparam int PTS_DIR_BIT = 6;
	localparam int PTS_EVT_BIT = 0;

	// Reset values
	localparam logic [3:0] PTS_POST_RST = 4'h0;
	localparam logic [1:0] PTS_PRE_RST = 2'h0;
	localparam logic PTS_EN_RST = 1'b0;
	localparam logic [7:0] PTS_PERL_RST = 8'h00;
	localparam logic [3:0] PTS_PERH_RST = 4'h0;
	localparam logic [11:0] PTS_COUNT_RST = 12'h000;

	// Instruction rate is aclk divided by four
	localparam logic [1:0] PTS_QUARTER_LAST = 2'h3;

	// Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
	localparam logic [5:0] PTS_PRE_LAST_1 = 6'h00;
	localparam logic [5:0] PTS_PRE_LAST_4 = 6'h03;
	localparam logic [5:0] PTS_PRE_LAST_16 = 6'h0F;
	localparam logic [5:0] PTS_PRE_LAST_64 = 6'h3F;

	// AXI response codes
	localparam logic [1:0] PTS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PTS_RESP_SLVERR = 2'h2;

	// Time base counting modes
	typedef enum logic [1:0] {
		PTS_FREE = 2'b00,
		PTS_SINGLE = 2'b01,
		PTS_UPDN = 2'b10,
		PTS_UPDN_DBL = 2'b11
	} pts_mode_type;

endpackage

//--- hw/pts_timebase.sv
// PWM time base: 12-bit up/down counter with scalers and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Up/down modes count up to period, then count down from next tick.
// - Read-only direction bit is one while counting down.
// - Up/down start holds PWM outputs inactive until first count down.
// - Counter tick is aclk/4 divided by 1, 4, 16 or 64.
// - Prescaler clears on count write, control write and reset.
// - Control writes never change the counter value.
// - Events outside single-shot pass a 4-bit postscaler, 1:1 to 1:16.
// - Postscaler clears on count write, control write and reset.
// - Free-running: event at period match, counter to zero on the same tick.
// - Single-shot: one event at match, count zero, enable cleared, no postscale.
// - Up/down: event each time count turns from down to up at zero.
// - Double update: events at zero and at period match.
// - Period is high nibble low 4 bits over low byte.
// - Free and single-shot load period when counter resets after match.
// - Up/down modes load period while counter is zero.
// - While disabled the active period follows the buffer.
// - Prescale field 00,01,10,11 gives 1,4,16,64.
// - Postscale field N gives ratio N+1.
// - Clearing enable stops counting and keeps the count.
module pts_timebase
	import pts_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Time base state for compare units
	output logic [11:0] timebase_count,
	output logic count_direction_flag,
	output logic period_match,
	output logic count_zero,
	output logic pwm_hold_inactive,
	// Time base event
	output logic timebase_event,
	output logic timebase_event_flag
);

	// Word match of an address against a register offset
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
		hits = (addr[7:2] == off[7:2]);
	endfunction

	// Prescaler terminal count for a select code
	function automatic logic [5:0] pre_last(input logic [1:0] sel);
		unique case (sel)
			2'b00: pre_last = PTS_PRE_LAST_1;
			2'b01: pre_last = PTS_PRE_LAST_4;
			2'b10: pre_last = PTS_PRE_LAST_16;
			default: pre_last = PTS_PRE_LAST_64;
		endcase
	endfunction

	// Bus state
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic do_write;

	// Time base state
	pts_mode_type mode_r, mode_nxt;
	logic [1:0] pre_sel_r, pre_sel_nxt, quarter_r, quarter_nxt;
	logic [3:0] post_sel_r, post_sel_nxt, post_cnt_r, post_cnt_nxt, per_hi_r, per_hi_nxt;
	logic [5:0] pre_cnt_r, pre_cnt_nxt;
	logic [7:0] per_lo_r, per_lo_nxt;
	logic [11:0] cnt_r, cnt_nxt, act_per_r, act_per_nxt, per_buf;
	logic en_r, en_nxt, dir_r, dir_nxt, hold_r, hold_nxt;
	logic flag_r, flag_nxt, evt_r, evt_nxt, match_r, match_nxt, zero_r, zero_nxt;
	logic cyc_en, tick, raw_evt;

	assign per_buf = {per_hi_r, per_lo_r};
	assign cyc_en = (quarter_r == PTS_QUARTER_LAST);
	assign tick = cyc_en && en_r && (pre_cnt_r == pre_last(pre_sel_r));
	assign do_write = aw_held_r && w_held_r && !bvalid_r;

	// Bus handshake and read mux
	always_comb
	begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awready_nxt = awready_r;
		wready_nxt = wready_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_held_nxt = 1'b1;
			awready_nxt = 1'b0;
			waddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_held_nxt = 1'b1;
			wready_nxt = 1'b0;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (hits(waddr_r, PTS_CTRL0_OFF) || hits(waddr_r, PTS_CTRL1_OFF) ||
				hits(waddr_r, PTS_PERL_OFF) || hits(waddr_r, PTS_PERH_OFF) ||
				hits(waddr_r, PTS_COUNT_OFF) || hits(waddr_r, PTS_ACTPER_OFF) ||
				hits(waddr_r, PTS_EVT_OFF)) ? PTS_RESP_OKAY : PTS_RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready)
		begin
			bvalid_nxt = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt = 1'b1;
		end
		if (s_axi_arvalid && arready_r)
		begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = PTS_RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (hits(s_axi_araddr, PTS_CTRL0_OFF))
				rdata_nxt[7:0] = {post_sel_r, pre_sel_r, mode_r};
			else if (hits(s_axi_araddr, PTS_CTRL1_OFF))
				rdata_nxt[7:0] = {en_r, dir_r, 6'h00};
			else if (hits(s_axi_araddr, PTS_PERL_OFF))
				rdata_nxt[7:0] = per_lo_r;
			else if (hits(s_axi_araddr, PTS_PERH_OFF))
				rdata_nxt[3:0] = per_hi_r;
			else if (hits(s_axi_araddr, PTS_COUNT_OFF))
				rdata_nxt[11:0] = cnt_r;
			else if (hits(s_axi_araddr, PTS_ACTPER_OFF))
				rdata_nxt[11:0] = act_per_r;
			else if (hits(s_axi_araddr, PTS_EVT_OFF))
				rdata_nxt[PTS_EVT_BIT] = flag_r;
			else
				rresp_nxt = PTS_RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready)
		begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	// Bus registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= PTS_RESP_OKAY;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= PTS_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Counter, scalers, period buffer and event flag
	always_comb
	begin
		mode_nxt = mode_r;
		pre_sel_nxt = pre_sel_r;
		post_sel_nxt = post_sel_r;
		en_nxt = en_r;
		dir_nxt = dir_r;
		hold_nxt = hold_r;
		per_lo_nxt = per_lo_r;
		per_hi_nxt = per_hi_r;
		act_per_nxt = act_per_r;
		cnt_nxt = cnt_r;
		pre_cnt_nxt = pre_cnt_r;
		post_cnt_nxt = post_cnt_r;
		flag_nxt = flag_r;
		quarter_nxt = quarter_r + 2'h1;
		raw_evt = 1'b0;
		evt_nxt = 1'b0;
		match_nxt = 1'b0;
		zero_nxt = 1'b0;
		if (cyc_en)
			pre_cnt_nxt = (pre_cnt_r == pre_last(pre_sel_r)) ? 6'h00 : pre_cnt_r + 6'h01;
		// no tick while disabled, count kept
		if (tick)
		begin
			unique case (mode_r)
				PTS_FREE, PTS_SINGLE:
				begin
					if (cnt_r >= act_per_r)
					begin
						match_nxt = 1'b1;
						raw_evt = 1'b1;
						cnt_nxt = 12'h000;
						act_per_nxt = per_buf;
						if (mode_r == PTS_SINGLE)
							en_nxt = 1'b0;
					end
					else
						cnt_nxt = cnt_r + 12'h001;
				end
				PTS_UPDN, PTS_UPDN_DBL:
				begin
					if (!dir_r)
					begin
						if (cnt_r >= act_per_r)
						begin
							dir_nxt = 1'b1;
							match_nxt = 1'b1;
							hold_nxt = 1'b0;
							if (cnt_r != 12'h000)
								cnt_nxt = cnt_r - 12'h001;
							if (mode_r == PTS_UPDN_DBL)
								raw_evt = 1'b1;
						end
						else
							cnt_nxt = cnt_r + 12'h001;
					end
					else if (cnt_r == 12'h000)
					begin
						dir_nxt = 1'b0;
						cnt_nxt = 12'h001;
						zero_nxt = 1'b1;
						raw_evt = 1'b1;
					end
					else
						cnt_nxt = cnt_r - 12'h001;
				end
			endcase
		end
		if (mode_r[1] && cnt_r == 12'h000)
			act_per_nxt = per_buf;
		if (!en_r)
		begin
			act_per_nxt = per_buf;
			hold_nxt = mode_r[1];
		end
		if (raw_evt)
		begin
			if (mode_r == PTS_SINGLE)
				evt_nxt = 1'b1;
			else if (post_cnt_r == post_sel_r)
			begin
				evt_nxt = 1'b1;
				post_cnt_nxt = 4'h0;
			end
			else
				post_cnt_nxt = post_cnt_r + 4'h1;
		end
		// Register writes override counting
		if (do_write && wstrb_r[0])
		begin
			if (hits(waddr_r, PTS_CTRL0_OFF) || hits(waddr_r, PTS_CTRL1_OFF) ||
				hits(waddr_r, PTS_COUNT_OFF))
			begin
				pre_cnt_nxt = 6'h00;
				post_cnt_nxt = 4'h0;
			end
			if (hits(waddr_r, PTS_CTRL0_OFF))
			begin
				// mode changes expected only while disabled
				mode_nxt = pts_mode_type'(wdata_r[PTS_MODE_LSB +: 2]);
				pre_sel_nxt = wdata_r[PTS_PRE_LSB +: 2];
				post_sel_nxt = wdata_r[PTS_POST_LSB +: 4];
			end
			if (hits(waddr_r, PTS_CTRL1_OFF))
				en_nxt = wdata_r[PTS_EN_BIT];
			if (hits(waddr_r, PTS_PERL_OFF))
				per_lo_nxt = wdata_r[7:0];
			if (hits(waddr_r, PTS_PERH_OFF))
				per_hi_nxt = wdata_r[3:0];
			if (hits(waddr_r, PTS_COUNT_OFF))
				cnt_nxt[7:0] = wdata_r[7:0];
			if (hits(waddr_r, PTS_EVT_OFF) && wdata_r[PTS_EVT_BIT])
				flag_nxt = 1'b0;
		end
		if (do_write && wstrb_r[1] && hits(waddr_r, PTS_COUNT_OFF))
		begin
			cnt_nxt[11:8] = wdata_r[11:8];
			pre_cnt_nxt = 6'h00;
			post_cnt_nxt = 4'h0;
		end
		if (evt_nxt)
			flag_nxt = 1'b1;
	end

	// Time base registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_r <= PTS_FREE;
			pre_sel_r <= PTS_PRE_RST;
			post_sel_r <= PTS_POST_RST;
			en_r <= PTS_EN_RST;
			dir_r <= 1'b0;
			hold_r <= 1'b0;
			per_lo_r <= PTS_PERL_RST;
			per_hi_r <= PTS_PERH_RST;
			act_per_r <= PTS_COUNT_RST;
			cnt_r <= PTS_COUNT_RST;
			pre_cnt_r <= 6'h00;
			post_cnt_r <= 4'h0;
			quarter_r <= 2'h0;
			flag_r <= 1'b0;
			evt_r <= 1'b0;
			match_r <= 1'b0;
			zero_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			pre_sel_r <= pre_sel_nxt;
			post_sel_r <= post_sel_nxt;
			en_r <= en_nxt;
			dir_r <= dir_nxt;
			hold_r <= hold_nxt;
			per_lo_r <= per_lo_nxt;
			per_hi_r <= per_hi_nxt;
			act_per_r <= act_per_nxt;
			cnt_r <= cnt_nxt;
			pre_cnt_r <= pre_cnt_nxt;
			post_cnt_r <= post_cnt_nxt;
			quarter_r <= quarter_nxt;
			flag_r <= flag_nxt;
			evt_r <= evt_nxt;
			match_r <= match_nxt;
			zero_r <= zero_nxt;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign timebase_count = cnt_r;
	assign count_direction_flag = dir_r;
	assign period_match = match_r;
	assign count_zero = zero_r;
	assign pwm_hold_inactive = hold_r;
	assign timebase_event = evt_r;
	assign timebase_event_flag = flag_r;

endmodule // pts_timebase

`default_nettype wire
